// *** inc/flash_regs_pkg.sv ***
package flash_regs_pkg;

  // ==========================================================
  // register byte offsets, one aligned word each
  localparam logic [7:0] OFF_INDEX  = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_PROT   = 8'h08;
  localparam logic [7:0] OFF_CCOB   = 8'h0c;
  localparam logic [7:0] OFF_RSV1   = 8'h10;
  localparam logic [7:0] OFF_RSV2   = 8'h14;
  localparam logic [7:0] OFF_RSV3   = 8'h18;
  localparam logic [7:0] OFF_RSV4   = 8'h1c;
  localparam logic [7:0] OFF_OPT    = 8'h20;
  localparam logic [7:0] OFF_RSV5   = 8'h24;
  localparam logic [7:0] OFF_RSV6   = 8'h28;
  localparam logic [7:0] OFF_RSV7   = 8'h2c;

  // ==========================================================
  // field positions
  localparam int STAT_DONE_BIT  = 7;
  localparam int STAT_PVIOL_BIT = 4;
  localparam int DFP_OPEN_BIT   = 7;
  localparam int IDX_W          = 3;
  localparam int CCOB_WORDS     = 6;
  localparam logic [2:0] CCOB_LAST_IDX = 3'h5;

  // ==========================================================
  // reset values and configuration loading
  localparam logic [17:0] CFG_PROT_ADDR   = 18'h3ff0d;
  localparam logic [17:0] CFG_OPT_ADDR    = 18'h3ff0e;
  localparam logic [3:0]  SIZE_FULL       = 4'hf;
  localparam logic [7:0]  OPT_FAULT       = 8'hff;
  localparam logic [7:0]  OPT_RST         = 8'hff;

  // ==========================================================
  // protected data-flash window: base plus (size+1) sectors of 256 bytes
  localparam logic [17:0] DFLASH_PROT_BASE = 18'h04400;
  localparam logic [7:0]  SECTOR_LAST      = 8'hff;
  localparam logic [1:0]  DFLASH_PAGE      = 2'h0;

  // ==========================================================
  // command codes that the protection check looks at
  localparam logic [7:0] CMD_ERASE_BLOCK  = 8'h09;
  localparam logic [7:0] CMD_PROG_DFLASH  = 8'h11;
  localparam logic [7:0] CMD_ERASE_DSECT  = 8'h12;

  typedef enum logic [2:0] {
    ST_LD_PROT = 3'b000,
    ST_LD_OPT  = 3'b001,
    ST_READY   = 3'b011,
    ST_BUSY    = 3'b010
  } state_e_t;

  typedef struct packed {
    logic       ack;
    logic       dbl_fault;
    logic [7:0] data;
  } cfg_rsp_t;

  typedef struct packed {
    logic             done;
    logic             res_we;
    logic [IDX_W-1:0] res_idx;
    logic [15:0]      res_data;
  } cmd_ret_t;

  typedef struct packed {
    logic       open;
    logic [3:0] size;
  } prot_cfg_t;

endpackage

// *** verilog/byte_lane_merge.sv ***
module byte_lane_merge #(
  parameter int BYTES = 2
) (
  // data
  input  wire logic [8*BYTES-1:0] old_word,
  input  wire logic [8*BYTES-1:0] new_word,
  input  wire logic [BYTES-1:0]   sel,
  output logic      [8*BYTES-1:0] merged
);

  // ==========================================================
  // per-lane choice
  for (genvar i = 0; i < BYTES; i++)
  begin : g_lane
    assign merged[8*i +: 8] = sel[i] ? new_word[8*i +: 8] : old_word[8*i +: 8];
  end

endmodule // byte_lane_merge

// *** verilog/dflash_range_check.sv ***
module dflash_range_check (
  // target and protection setting
  input  wire logic [17:0]               addr,
  input  wire flash_regs_pkg::prot_cfg_t prot,
  // verdict
  output logic                           in_window,
  output logic                           any_protected
);

  logic [17:0] last_addr;

  // ==========================================================
  // window end = base + size*256 + 255
  assign last_addr     = 18'(flash_regs_pkg::DFLASH_PROT_BASE
                         + {6'h00, prot.size, flash_regs_pkg::SECTOR_LAST});
  assign any_protected = !prot.open;
  assign in_window     = !prot.open && (addr >= flash_regs_pkg::DFLASH_PROT_BASE)
                         && (addr <= last_addr);

endmodule // dflash_range_check

// *** verilog/flash_protect_command_regs.sv ***
// Function
// - protection writes accepted only when adding protection: size up, open 1 to 0
// - open bit 7: 0 protects the size range, 1 disables protection
// - protection register loaded at reset from configuration byte 0x3_FF0D
// - double-bit fault on that byte: open cleared, size all ones
// - window starts 0x0_4400, (N+1)*256 bytes long
// - program or erase on protected address refused, violation flag set
// - data-flash block erase refused while any sector protected
// - six 16-bit command words, chosen by 3-bit index, byte access allowed
// - software loads words, writes 1 to complete flag, flag clears, command launches
// - command words locked while complete flag is 0, released at completion
// - results land in command words, read after flag returns to 1
// - index 110 or 111: writes ignored, reads give 0x0000
// - word 0: command code high, address bits 17:16 low
// - word 1: address 15:0; words 2 to 5: data 0 to 3
// - seven factory-reserved registers read zero, ignore writes
// - option register readable, writes ignored
// - option register loaded at reset from configuration byte 0x3_FF0E
// - double-bit fault on option byte sets every option bit
// - complete flag 0: no new command, command word writes ignored
//
// Implementation choices: the Wishbone slave port and the placing of the registers.
module flash_protect_command_regs (
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       rst,
  // wishbone slave
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [7:0]                 wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  // configuration byte reads after reset
  output logic                            cfg_req,
  output logic      [17:0]                cfg_addr,
  input  wire flash_regs_pkg::cfg_rsp_t   cfg_rsp,
  // command engine
  output logic                            cmd_launch,
  output logic      [5:0][15:0]           command_object_array,
  input  wire flash_regs_pkg::cmd_ret_t   cmd_ret,
  output logic                            command_complete_flag,
  // protection and option state
  output logic                            dflash_protect_open,
  output logic      [3:0]                 dflash_protect_size,
  output logic      [7:0]                 option_nonvolatile_bits,
  output logic                            protection_violation_flag
);

  typedef struct packed {
    flash_regs_pkg::state_e_t st;
    logic                     ack;
    logic [31:0]              rdata;
    logic                     launch;
    logic [2:0]               idx;
    logic [5:0][15:0]         ccob;
    flash_regs_pkg::prot_cfg_t prot;
    logic [7:0]               opt;
    logic                     pviol;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic        hit;
  logic        rd_hit;
  logic        wr_hit;
  logic [7:0]  word_adr;
  logic        idx_ok;
  logic [15:0] ccob_cur;
  logic [15:0] ccob_merged;
  logic [7:0]  cmd_code;
  logic [17:0] cmd_addr;
  logic        in_window;
  logic        any_prot;
  logic        refuse;
  logic        prot_ok;
  flash_regs_pkg::prot_cfg_t wr_prot;

  // ==========================================================
  // bus decode
  assign word_adr = {wb_adr_i[7:2], 2'b00};
  // the bus stalls until both configuration bytes are in
  assign hit      = wb_cyc_i && wb_stb_i && !s_q.ack
                    && ((s_q.st == flash_regs_pkg::ST_READY)
                        || (s_q.st == flash_regs_pkg::ST_BUSY));
  assign rd_hit   = hit && !wb_we_i;
  assign wr_hit   = hit && wb_we_i;
  assign idx_ok   = s_q.idx <= flash_regs_pkg::CCOB_LAST_IDX;
  // guarded so an unimplemented index never indexes past the array
  assign ccob_cur = idx_ok ? s_q.ccob[s_q.idx] : 16'h0000;

  byte_lane_merge #(
    .BYTES (2)
  ) u_merge (
    .old_word (ccob_cur),
    .new_word (wb_dat_i[15:0]),
    .sel      (wb_sel_i[1:0]),
    .merged   (ccob_merged)
  );

  // ==========================================================
  // launch-time protection check
  assign cmd_code = s_q.ccob[0][15:8];
  assign cmd_addr = {s_q.ccob[0][1:0], s_q.ccob[1]};

  dflash_range_check u_range (
    .addr          (cmd_addr),
    .prot          (s_q.prot),
    .in_window     (in_window),
    .any_protected (any_prot)
  );

  always_comb
  begin
    refuse = 1'b0;
    if (((cmd_code == flash_regs_pkg::CMD_PROG_DFLASH)
         || (cmd_code == flash_regs_pkg::CMD_ERASE_DSECT)) && in_window)
    begin
      refuse = 1'b1;
    end
    if ((cmd_code == flash_regs_pkg::CMD_ERASE_BLOCK)
        && (cmd_addr[17:16] == flash_regs_pkg::DFLASH_PAGE) && any_prot)
    begin
      refuse = 1'b1;
    end
  end

  // ==========================================================
  // protection write filter: only more protection gets through
  assign wr_prot = '{open: wb_dat_i[flash_regs_pkg::DFP_OPEN_BIT],
                     size: wb_dat_i[3:0]};
  always_comb
  begin
    prot_ok = 1'b0;
    if (!wr_prot.open || s_q.prot.open)
    begin
      // while open, size has no effect so any value may be set
      prot_ok = s_q.prot.open || (wr_prot.size >= s_q.prot.size);
    end
  end

  // ==========================================================
  // next state
  always_comb
  begin
    s_d        = s_q;
    s_d.ack    = hit;
    s_d.launch = 1'b0;
    s_d.rdata  = 32'h0000_0000;
    case (s_q.st)
      flash_regs_pkg::ST_LD_PROT:
      begin
        if (cfg_rsp.ack)
        begin
          if (cfg_rsp.dbl_fault)
          begin
            s_d.prot.open = 1'b0;
            s_d.prot.size = flash_regs_pkg::SIZE_FULL;
          end
          else
          begin
            s_d.prot.open = cfg_rsp.data[flash_regs_pkg::DFP_OPEN_BIT];
            s_d.prot.size = cfg_rsp.data[3:0];
          end
          s_d.st = flash_regs_pkg::ST_LD_OPT;
        end
      end
      flash_regs_pkg::ST_LD_OPT:
      begin
        if (cfg_rsp.ack)
        begin
          s_d.opt = cfg_rsp.dbl_fault ? flash_regs_pkg::OPT_FAULT
                                      : cfg_rsp.data;
          s_d.st  = flash_regs_pkg::ST_READY;
        end
      end
      flash_regs_pkg::ST_BUSY:
      begin
        if (cmd_ret.res_we && (cmd_ret.res_idx <= flash_regs_pkg::CCOB_LAST_IDX))
        begin
          s_d.ccob[cmd_ret.res_idx] = cmd_ret.res_data;
        end
        if (cmd_ret.done)
        begin
          s_d.st = flash_regs_pkg::ST_READY;
        end
      end
      flash_regs_pkg::ST_READY:
      begin
      end
      default:
      begin
        s_d.st = flash_regs_pkg::ST_LD_PROT;
      end
    endcase

    // ---- register writes
    if (wr_hit)
    begin
      case (word_adr)
        flash_regs_pkg::OFF_INDEX:
        begin
          if (wb_sel_i[0])
          begin
            s_d.idx = wb_dat_i[2:0];
          end
        end
        flash_regs_pkg::OFF_CCOB:
        begin
          // busy locks the words; unimplemented slots swallow the write
          if ((s_q.st == flash_regs_pkg::ST_READY) && idx_ok)
          begin
            s_d.ccob[s_q.idx] = ccob_merged;
          end
        end
        flash_regs_pkg::OFF_PROT:
        begin
          if (wb_sel_i[0] && prot_ok)
          begin
            s_d.prot = wr_prot;
          end
        end
        flash_regs_pkg::OFF_STATUS:
        begin
          if (wb_sel_i[0])
          begin
            if (wb_dat_i[flash_regs_pkg::STAT_PVIOL_BIT])
            begin
              s_d.pviol = 1'b0;
            end
            if (wb_dat_i[flash_regs_pkg::STAT_DONE_BIT]
                && (s_q.st == flash_regs_pkg::ST_READY))
            begin
              if (refuse)
              begin
                s_d.pviol = 1'b1;
              end
              else
              begin
                s_d.st     = flash_regs_pkg::ST_BUSY;
                s_d.launch = 1'b1;
              end
            end
          end
        end
        default:
        begin
          // option and reserved registers ignore writes
        end
      endcase
    end

    // ---- read data
    if (rd_hit)
    begin
      case (word_adr)
        flash_regs_pkg::OFF_INDEX:
        begin
          s_d.rdata[2:0] = s_q.idx;
        end
        flash_regs_pkg::OFF_STATUS:
        begin
          s_d.rdata[flash_regs_pkg::STAT_DONE_BIT]  = s_q.st == flash_regs_pkg::ST_READY;
          s_d.rdata[flash_regs_pkg::STAT_PVIOL_BIT] = s_q.pviol;
        end
        flash_regs_pkg::OFF_PROT:
        begin
          s_d.rdata[flash_regs_pkg::DFP_OPEN_BIT] = s_q.prot.open;
          s_d.rdata[3:0]                          = s_q.prot.size;
        end
        flash_regs_pkg::OFF_CCOB:
        begin
          s_d.rdata[15:0] = ccob_cur;
        end
        flash_regs_pkg::OFF_OPT:
        begin
          s_d.rdata[7:0] = s_q.opt;
        end
        default:
        begin
          // reserved and unmapped words read zero
          s_d.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s_q        <= '0;
      s_q.st     <= flash_regs_pkg::ST_LD_PROT;
      s_q.prot   <= {1'b0, flash_regs_pkg::SIZE_FULL};
      s_q.opt    <= flash_regs_pkg::OPT_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs
  assign wb_dat_o                  = s_q.rdata;
  assign wb_ack_o                  = s_q.ack;
  assign cfg_req                   = (s_q.st == flash_regs_pkg::ST_LD_PROT)
                                     || (s_q.st == flash_regs_pkg::ST_LD_OPT);
  assign cfg_addr                  = (s_q.st == flash_regs_pkg::ST_LD_OPT)
                                     ? flash_regs_pkg::CFG_OPT_ADDR
                                     : flash_regs_pkg::CFG_PROT_ADDR;
  assign cmd_launch                = s_q.launch;
  assign command_object_array      = s_q.ccob;
  assign command_complete_flag     = s_q.st == flash_regs_pkg::ST_READY;
  assign dflash_protect_open       = s_q.prot.open;
  assign dflash_protect_size       = s_q.prot.size;
  assign option_nonvolatile_bits   = s_q.opt;
  assign protection_violation_flag = s_q.pviol;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  logic run_q;
  logic rd_zero_q;
  always_ff @(posedge clock)
  begin
    run_q     <= !rst && !cfg_req;
    rd_zero_q <= rd_hit && (((word_adr == flash_regs_pkg::OFF_CCOB) && !idx_ok)
                 || (word_adr == flash_regs_pkg::OFF_RSV1)
                 || (word_adr == flash_regs_pkg::OFF_RSV7));
  end

  open_stays_closed_a: assert property (run_q && !cfg_req && !dflash_protect_open
    |=> !dflash_protect_open) else $error("protection open bit reopened");
  size_only_grows_a: assert property (run_q && !cfg_req && !dflash_protect_open
    |=> dflash_protect_size >= $past(dflash_protect_size))
    else $error("protected size shrank");
  prot_fault_load_a: assert property (s_q.st == flash_regs_pkg::ST_LD_PROT
    && cfg_rsp.ack && cfg_rsp.dbl_fault |=> !dflash_protect_open
    && dflash_protect_size == 4'hf) else $error("fault did not fully protect");
  opt_fault_load_a: assert property (s_q.st == flash_regs_pkg::ST_LD_OPT
    && cfg_rsp.ack && cfg_rsp.dbl_fault |=> option_nonvolatile_bits == 8'hff)
    else $error("option fault not all ones");
  launch_clears_flag_a: assert property ($rose(cmd_launch)
    |-> !command_complete_flag && $past(command_complete_flag))
    else $error("launch without flag clear");
  words_locked_a: assert property (!command_complete_flag && !cfg_req && !cmd_ret.res_we
    |=> command_object_array == $past(command_object_array))
    else $error("command words changed while busy");
  refuse_no_launch_a: assert property ($rose(protection_violation_flag)
    |-> !cmd_launch && command_complete_flag)
    else $error("violation with launch");
  zero_reads_a: assert property (rd_zero_q |-> wb_ack_o && wb_dat_o == 32'h0000_0000)
    else $error("unimplemented slot read nonzero");
  option_read_only_a: assert property (run_q && !cfg_req
    |=> $stable(option_nonvolatile_bits)) else $error("option register changed");
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

endmodule // flash_protect_command_regs

// *** verification/testbench.sv ***
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // design ports
  logic                     clock, rst;
  logic                     wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]               wb_adr_i;
  logic [3:0]               wb_sel_i;
  logic [31:0]              wb_dat_i, wb_dat_o;
  logic                     cfg_req, cmd_launch, ccf, dp_open, viol_flag;
  logic [17:0]              cfg_addr;
  flash_regs_pkg::cfg_rsp_t cfg_rsp;
  flash_regs_pkg::cmd_ret_t cmd_ret;
  logic [5:0][15:0]         words;
  logic [3:0]               dp_size;
  logic [7:0]               opt_bits;

  // ==========================================================
  // reference model and bookkeeping
  int          prot_open, prot_size, opt_val, cur_idx, done_flag, viol;
  int          fails, n_compared, cycles;
  int          word_m[8];
  logic [31:0] rd;
  logic [31:0] pw;
  logic        launch_seen;

  flash_protect_command_regs dut (
    .clock(clock), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cfg_req(cfg_req), .cfg_addr(cfg_addr), .cfg_rsp(cfg_rsp),
    .cmd_launch(cmd_launch), .command_object_array(words), .cmd_ret(cmd_ret),
    .command_complete_flag(ccf), .dflash_protect_open(dp_open),
    .dflash_protect_size(dp_size), .option_nonvolatile_bits(opt_bits),
    .protection_violation_flag(viol_flag)
  );

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // ==========================================================
  // verdict, compares and a hang guard
  task automatic report_and_stop();
    if (fails == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk_read(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: read %h expected %h", $time, got, exp);
      fails++;
    end
  endtask

  task automatic chk_port(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: port %h expected %h", $time, got, exp);
      fails++;
    end
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      fails++;
      report_and_stop();
    end
  end

  // ==========================================================
  // bus master: request held until ack is sampled, then released
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    input logic [3:0] sel);
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    // only the cycle ceiling ends a wait for ack
    do
    begin
      @(posedge clock);
    end
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    launch_seen = cmd_launch;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_dat_i <= $urandom;
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0, 4'hf);
    chk_read(rd, exp);
  endtask

  task automatic set_idx(input int i);
    wb(1'b1, flash_regs_pkg::OFF_INDEX, i, 4'h1);
    cur_idx = i & 7;
  endtask

  task automatic wr_word(input int i, input int d, input logic [3:0] sel);
    int mask;
    set_idx(i);
    wb(1'b1, flash_regs_pkg::OFF_CCOB, d, sel);
    mask = (sel[0] ? 32'hff : 32'h0) | (sel[1] ? 32'hff00 : 32'h0);
    if (done_flag != 0 && cur_idx < 6)
      word_m[cur_idx] = (word_m[cur_idx] & ~mask) | (d & mask);
  endtask

  task automatic rd_word();
    rd_chk(flash_regs_pkg::OFF_CCOB, cur_idx < 6 ? word_m[cur_idx] : 0);
  endtask

  // ==========================================================
  // configuration bytes after reset; idle data is inverted so stale values show
  task automatic cfg_give(input logic [17:0] adr, input logic [7:0] d, input logic dbl);
    do
    begin
      @(posedge clock);
    end
    while (cfg_req !== 1'b1);
    chk_port(cfg_addr, adr);
    cfg_rsp <= '{ack: 1'b1, dbl_fault: dbl, data: d};
    @(posedge clock);
    cfg_rsp <= '{ack: 1'b0, dbl_fault: ~dbl, data: ~d};
  endtask

  task automatic cfg_load(input logic [7:0] pb, input logic [7:0] ob, input logic dbl);
    cfg_give(flash_regs_pkg::CFG_PROT_ADDR, pb, dbl);
    cfg_give(flash_regs_pkg::CFG_OPT_ADDR, ob, dbl);
    prot_open = dbl ? 0 : pb[7];
    prot_size = dbl ? 15 : pb[3:0];
    opt_val = dbl ? 255 : ob;
    done_flag = 1;
    rd_chk(flash_regs_pkg::OFF_PROT, prot_open * 128 + prot_size);
    rd_chk(flash_regs_pkg::OFF_OPT, opt_val);
    chk_port({ccf, dp_open, dp_size, opt_bits}, {1'b1, prot_open[0], prot_size[3:0],
             opt_val[7:0]});
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    done_flag = 0;
    viol = 0;
    cur_idx = 0;
    foreach (word_m[i]) word_m[i] = 0;
  endtask

  // ==========================================================
  // commands
  function automatic bit refused(input int code, input int adr);
    if (prot_open != 0)
      return 1'b0;
    if (code == 8'h11 || code == 8'h12)
      return adr >= 18'h04400 && adr <= 18'h04400 + prot_size * 256 + 255;
    return code == 8'h09 && adr < 18'h10000;
  endfunction

  task automatic engine_finish();
    int i;
    int d;
    i = 2 + $urandom % 6;
    d = $urandom & 16'hffff;
    @(posedge clock);
    cmd_ret <= '{done: 1'b0, res_we: 1'b1, res_idx: i[2:0], res_data: d[15:0]};
    @(posedge clock);
    cmd_ret <= '{done: 1'b1, res_we: 1'b0, res_idx: 3'h0, res_data: 16'h0};
    @(posedge clock);
    cmd_ret <= '0;
    if (i < 6)
      word_m[i] = d;
    done_flag = 1;
    set_idx(i);
    rd_word();
  endtask

  task automatic launch(input int code, input int adr, input bit clr);
    bit bad;
    wr_word(0, {code[7:0], 6'h0, adr[17:16]}, 4'h3);
    wr_word(1, adr[15:0], 4'h3);
    bad = refused(code, adr);
    wb(1'b1, flash_regs_pkg::OFF_STATUS, clr ? 32'h90 : 32'h80, 4'h1);
    if (clr)
      viol = 0;
    if (bad)
      viol = 1;
    else
      done_flag = 0;
    chk_port(launch_seen, !bad);
    rd_chk(flash_regs_pkg::OFF_STATUS, done_flag * 128 + viol * 16);
    chk_port({ccf, viol_flag}, {done_flag[0], viol[0]});
    if (!bad)
    begin
      wr_word(4, $urandom, 4'h3);
      rd_word();
      engine_finish();
    end
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    rst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    cfg_rsp = '0;
    cmd_ret = '0;
    {fails, n_compared, cycles} = '0;
    void'($urandom(32'h953e0388));
    do_reset();
    cfg_load(8'h80 | 8'($urandom & 8'h0f), 8'($urandom), 1'b0);
    // reserved, unmapped and option writes must all be dropped
    foreach (word_m[i])
    begin
      wb(1'b1, flash_regs_pkg::OFF_RSV1 + 8'(i * 4) + (i > 3 ? 8'h4 : 8'h0), $urandom, 4'hf);
      rd_chk(flash_regs_pkg::OFF_RSV1 + 8'(i * 4) + (i > 3 ? 8'h4 : 8'h0), 0);
    end
    wb(1'b1, flash_regs_pkg::OFF_OPT, $urandom, 4'hf);
    rd_chk(flash_regs_pkg::OFF_OPT, opt_val);
    for (int i = 0; i < 8; i++)
    begin
      wr_word(i, $urandom, 4'($urandom));
      rd_word();
    end
    for (int i = 0; i < 6; i++) chk_port(words[i], word_m[i]);
    launch(8'h11, 18'h04400, 1'b0);
    // random protection updates; every removal gets refused once open is 0
    repeat (12)
    begin
      // own copy of the written value: wb overwrites rd with the bus answer
      pw = $urandom;
      wb(1'b1, flash_regs_pkg::OFF_PROT, pw, 4'h1);
      if (int'(pw[7]) <= prot_open && (prot_open != 0 || int'(pw[3:0]) >= prot_size))
      begin
        prot_open = pw[7];
        prot_size = pw[3:0];
      end
      rd_chk(flash_regs_pkg::OFF_PROT, prot_open * 128 + prot_size);
      chk_port({dp_open, dp_size}, prot_open * 16 + prot_size);
    end
    wb(1'b1, flash_regs_pkg::OFF_PROT, prot_size, 4'h1);
    prot_open = 0;
    rd_chk(flash_regs_pkg::OFF_PROT, prot_size);
    launch(8'h11, 18'h04400 + prot_size * 256 + 255, 1'b0);
    launch(8'h12, 18'h04400, 1'b1);
    launch(8'h12, 18'h043ff, 1'b1);
    launch(8'h11, 18'h04400 + (prot_size + 1) * 256, 1'b0);
    launch(8'h09, 18'h00000, 1'b1);
    launch(8'h09, 18'h30000, 1'b1);
    do_reset();
    cfg_load(8'($urandom), 8'($urandom), 1'b1);
    for (int i = 0; i < 6; i++) chk_port(words[i], 0);
    report_and_stop();
  end

endmodule // testbench
